// ---- rtl/fs_status_core.sv ----
// status register, write-enable latch and busy timing of a serial flash
// assumes sck/ce_n/si/wp_n come from pins; status read by opcode or directly on status_o
`timescale 1ns/1ps

module fs_status_core
  import fs_pkg::*;
#(
  parameter int OP_CYC = FS_OP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic ce_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe_n,
  output fs_status_t status_o
);

  fs_status_t stat_q;
  fs_status_t snap_q;
  fs_status_t wr_w;
  fs_frame_t frm;
  logic ce_s;
  logic wp_s;
  logic ack_s;
  logic ack_t;
  logic ce_p_q;
  logic seen_q;
  logic req_q;
  logic susp_q;
  logic [FS_CNT_W-1:0] cnt_q;

  fs_sync #(.RST_VAL(1'b1)) u_ce (.clk(clk), .rst(rst), .d(ce_n), .q(ce_s));
  fs_sync #(.RST_VAL(1'b1)) u_wp (.clk(clk), .rst(rst), .d(wp_n), .q(wp_s));
  fs_sync u_ack (.clk(clk), .rst(rst), .d(ack_t), .q(ack_s));

  fs_link u_link (
    .sck(sck),
    .rst(rst),
    .ce_n(ce_n),
    .si(si),
    .req_t(req_q),
    .snap(snap_q),
    .ack_t(ack_t),
    .frame(frm),
    .so(so),
    .so_oe_n(so_oe_n)
  );

  // frame record is static once deselect is seen here
  wire ce_rise = ce_s & ~ce_p_q;
  wire fresh = ce_rise & (frm.seq != seen_q);
  wire [7:0] op = frm.op;
  wire busy = stat_q.busy;

  wire is_reset = op == FS_OP_RESET;
  wire is_susp = op == FS_OP_SUSP;
  wire busy_ok = (op == FS_OP_RDSR) | (op == FS_OP_RDERP) | is_reset | is_susp;
  wire take = fresh & (~busy | busy_ok);

  wire is_nv = fs_is_nv(op);
  wire is_gated = is_nv | fs_is_vol(op);
  wire wel_ok = take & is_gated & stat_q.write_enable_latch & ~busy;
  wire wr_lock = stat_q.status_write_disable & ~wp_s;
  wire is_write_status_cmd = op == FS_OP_WRITE_STATUS_CMD;
  wire do_write_status_cmd = wel_ok & is_write_status_cmd & ~wr_lock & (frm.nbytes == FS_NB_DATA);
  wire is_cer = (op == FS_OP_CER_A) | (op == FS_OP_CER_B);
  wire cer_blk = is_cer & (|stat_q.bp);
  wire start = wel_ok & is_nv & ~cer_blk & (~is_write_status_cmd | do_write_status_cmd);

  wire suspend = take & is_susp & busy;
  wire resume = take & (op == FS_OP_RESUME) & susp_q & ~busy;
  wire rst_cmd = take & is_reset;
  wire done = busy & (cnt_q == 16'h0001);
  wire set_wel = take & (op == FS_OP_WRITE_ENABLE_CMD) & ~busy;
  wire clr_wel = take & (op == FS_OP_WRITE_DISABLE_CMD) & ~busy;
  wire wel_cmd = set_wel | clr_wel | rst_cmd;

  assign wr_w = fs_status_t'(frm.data);

  // latch moves only on enable, disable, reset and completion
  wire wel_d = (done | rst_cmd | clr_wel) ? 1'b0 : (set_wel ? 1'b1 : stat_q.write_enable_latch);
  wire busy_d = (start | resume) ? 1'b1 : ((done | suspend | rst_cmd) ? 1'b0 : busy);
  wire susp_d = suspend ? 1'b1 : ((resume | rst_cmd) ? 1'b0 : susp_q);
  wire [FS_CNT_W-1:0] cnt_d = start ? FS_CNT_W'(OP_CYC) :
                              (rst_cmd ? '0 : ((busy & ~suspend) ? cnt_q - 16'h0001 : cnt_q));

  // non-volatile fields change only through an accepted status write
  wire [5:0] nv_d = do_write_status_cmd ? {wr_w.status_write_disable, wr_w.qe, wr_w.bp}
                            : {stat_q.status_write_disable, stat_q.qe, stat_q.bp};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= FS_STATUS_RST;
      cnt_q <= '0;
      susp_q <= 1'b0;
    end
    else
    begin
      stat_q <= {nv_d, wel_d, busy_d};
      cnt_q <= cnt_d;
      susp_q <= susp_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ce_p_q <= 1'b1;
      seen_q <= 1'b0;
    end
    else
    begin
      ce_p_q <= ce_s;
      if (ce_rise)
        seen_q <= frm.seq;
    end
  end

  // snapshot held stable until the link side acknowledges it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      snap_q <= FS_STATUS_RST;
      req_q <= 1'b0;
    end
    else if (req_q == ack_s)
    begin
      snap_q <= stat_q;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_o <= FS_STATUS_RST;
    else
      status_o <= {nv_d, wel_d, busy_d};
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  write_enable_cmd_sets_a: assert property (set_wel |=> stat_q.write_enable_latch)
    else $error("write enable did not set latch");

  write_disable_cmd_clears_a: assert property (clr_wel |=> !stat_q.write_enable_latch)
    else $error("write disable did not clear latch");

  wel_cause_a: assert property ($changed(stat_q.write_enable_latch) |-> $past(wel_cmd | done))
    else $error("latch changed without cause");

  write_status_cmd_locked_a: assert property (
    fresh && is_write_status_cmd && wr_lock && !busy |=> $stable({stat_q.status_write_disable, stat_q.qe, stat_q.bp}))
    else $error("locked status write changed bits");

  cer_guard_a: assert property (take && is_cer && (|stat_q.bp) && !busy |=> !stat_q.busy)
    else $error("full erase ran with protect set");

  no_latch_drop_a: assert property (
    take && is_gated && !stat_q.write_enable_latch && !busy
    |=> !stat_q.busy && $stable({stat_q.status_write_disable, stat_q.qe, stat_q.bp}))
    else $error("gated opcode acted without latch");

  done_clears_a: assert property (done |=> !stat_q.busy && !stat_q.write_enable_latch)
    else $error("completion left busy or latch set");

  busy_ignore_a: assert property (busy && fresh && !busy_ok && !done |=> $stable(stat_q))
    else $error("opcode acted while busy");

  busy_start_a: assert property (start |=> stat_q.busy && cnt_q == FS_CNT_W'(OP_CYC))
    else $error("write cycle did not start busy");

  busy_hold_a: assert property (
    busy && cnt_q > 16'h0001 && !(fresh && busy_ok) |=> stat_q.busy)
    else $error("busy dropped early");

  suspend_a: assert property (suspend |=> !stat_q.busy && susp_q ##0 $stable(cnt_q))
    else $error("suspend not taken");

  write_status_cmd_write_a: assert property (do_write_status_cmd |=> stat_q.qe == $past(wr_w.qe)
    && stat_q.bp == $past(wr_w.bp) && stat_q.status_write_disable == $past(wr_w.status_write_disable))
    else $error("status write did not store fields");

  write_enable_cmd_then_prog_c: cover property (set_wel ##[1:1000] start);
  suspend_resume_c: cover property (suspend ##[1:1000] resume);
  cer_blocked_c: cover property (take && cer_blk && stat_q.write_enable_latch);
  write_status_cmd_locked_c: cover property (fresh && is_write_status_cmd && wr_lock && stat_q.write_enable_latch);

endmodule : fs_status_core

// ---- rtl/fs_pkg.sv ----
// constants, types and opcode lists for the flash status block
// assumes a 40 MHz core clock and a serial link on its own clock
package fs_pkg;

  localparam int FS_CLK_MHZ = 40;
  localparam int FS_OP_TIME_NS = 2000;
  localparam int FS_OP_CYC = (FS_OP_TIME_NS * FS_CLK_MHZ + 999) / 1000;
  localparam int FS_CNT_W = 16;

  localparam logic [7:0] FS_STATUS_RST = 8'h00;
  localparam logic [1:0] FS_NB_OP = 2'h1;
  localparam logic [1:0] FS_NB_DATA = 2'h2;

  localparam logic [7:0] FS_OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] FS_OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] FS_OP_WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] FS_OP_RDSR = 8'h05;
  localparam logic [7:0] FS_OP_RDERP = 8'h81;
  localparam logic [7:0] FS_OP_RESET = 8'h99;
  localparam logic [7:0] FS_OP_SUSP = 8'h75;
  localparam logic [7:0] FS_OP_RESUME = 8'h7a;
  localparam logic [7:0] FS_OP_CER_A = 8'hc7;
  localparam logic [7:0] FS_OP_CER_B = 8'h60;

  // modifying opcodes that run an internal write cycle
  localparam logic [7:0] FS_NV_OPS [32] = '{
    8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20,
    8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc, 8'hc7, 8'h60, 8'h01,
    8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h18, 8'hfd, 8'he3,
    8'he4, 8'h2f, 8'ha6, 8'h91, 8'h7e, 8'h98, 8'he8, 8'h43};

  // modifying opcodes that only touch volatile state
  localparam logic [7:0] FS_VOL_OPS [6] = '{
    8'h63, 8'h83, 8'hc5, 8'hfb, 8'he1, 8'h4a};

  typedef struct packed {
    logic status_write_disable;
    logic qe;
    logic [3:0] bp;
    logic write_enable_latch;
    logic busy;
  } fs_status_t;

  typedef struct packed {
    logic seq;
    logic [1:0] nbytes;
    logic [7:0] op;
    logic [7:0] data;
  } fs_frame_t;

  function automatic logic fs_is_nv(input logic [7:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 32; i++)
      hit = hit | (op == FS_NV_OPS[i]);
    return hit;
  endfunction : fs_is_nv

  function automatic logic fs_is_vol(input logic [7:0] op);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 6; i++)
      hit = hit | (op == FS_VOL_OPS[i]);
    return hit;
  endfunction : fs_is_vol

endpackage : fs_pkg

// ---- rtl/fs_sync.sv ----
// two flip-flop level synchroniser
// assumes d is a level from another clock domain or a pin
`timescale 1ns/1ps
module fs_sync
  import fs_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : fs_sync

// ---- rtl/fs_link.sv ----
// serial side: shifts in opcode and data byte, shifts out status
// assumes mode 0 framing; sck runs only while ce_n is low
`timescale 1ns/1ps
module fs_link
  import fs_pkg::*;
(
  input wire logic sck,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic si,
  input wire logic req_t,
  input fs_status_t snap,
  output logic ack_t,
  output fs_frame_t frame,
  output logic so,
  output logic so_oe_n
);

  logic req_s;
  logic [2:0] bit_q;
  logic [1:0] nb_q;
  logic [6:0] sh_q;
  logic [7:0] tx_q;
  logic rd_q;
  fs_status_t st_q;

  wire frame_rst = rst | ce_n;
  wire [7:0] byte_w = {sh_q, si};
  wire byte_done = bit_q == 3'h7;
  wire is_rd = (nb_q == 2'h0) ? (byte_w == FS_OP_RDSR) : rd_q;
  wire [2:0] tx_idx = 3'h7 - bit_q;

  fs_sync u_req (.clk(sck), .rst(rst), .d(req_t), .q(req_s));

  // per-frame shift state, cleared while chip enable is high
  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_q <= 3'h0;
      nb_q <= 2'h0;
      sh_q <= 7'h00;
      rd_q <= 1'b0;
      tx_q <= 8'h00;
    end
    else
    begin
      bit_q <= bit_q + 3'h1;
      sh_q <= byte_w[6:0];
      if (byte_done)
      begin
        rd_q <= is_rd;
        tx_q <= st_q;
        if (nb_q != FS_NB_DATA)
          nb_q <= nb_q + 2'h1;
      end
    end
  end

  // status snapshot handshake and frame record persist across frames
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      st_q <= FS_STATUS_RST;
      ack_t <= 1'b0;
      frame <= '0;
    end
    else
    begin
      if (req_s != ack_t)
      begin
        st_q <= snap;
        ack_t <= req_s;
      end
      if (byte_done && nb_q == 2'h0)
      begin
        frame.op <= byte_w;
        frame.seq <= ~frame.seq;
        frame.nbytes <= FS_NB_OP;
      end
      else if (byte_done && nb_q == FS_NB_OP)
      begin
        frame.data <= byte_w;
        frame.nbytes <= FS_NB_DATA;
      end
    end
  end

  // output shifts on the falling edge, repeating until ce_n rises
  always_ff @(negedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      so <= 1'b0;
      so_oe_n <= 1'b1;
    end
    else if (rd_q)
    begin
      so <= tx_q[tx_idx];
      so_oe_n <= 1'b0;
    end
  end

endmodule : fs_link

// ---- verification/fs_host_model.sv ----
// host-side serial controller model driving frames into the status block
// assumes mode 0; link clock idle low outside frames, 125 ns period
`timescale 1ns/1ps
module fs_host_model (
  output logic sck,
  output logic ce_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [15:0] rd_q;
  initial
  begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
    rd_q = 16'h0000;
  end
  // opcode, data byte, then dummy bytes; last two bytes seen kept in rd_q
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input int nb);
    logic [31:0] sh;
    sh = {op, dat, 16'h0000};
    ce_n = 1'b0;
    #43.3;
    for (int i = 0; i < 8 * nb; i++)
    begin
      si = sh[31];
      sh = sh << 1;
      #62.5 sck = 1'b1;
      rd_q = {rd_q[14:0], so_oe_n ? ~rd_q[0] : so};
      #62.5 sck = 1'b0;
    end
    #40 ce_n = 1'b1;
    si = ~si;
    #160;
  endtask : xfer
endmodule : fs_host_model

// ---- verification/tb_fs_status_core.sv ----
// self-checking bench for the flash status block
// assumes the host model drives the serial link; status checked at pins
`timescale 1ns/1ps
module tb_fs_status_core;
  import fs_pkg::*;
  localparam int OPC = 400;
  logic clk, rst, wp_n, sck, ce_n, si, so, so_oe_n;
  fs_status_t status_o;
  int err_count, checks;
  fs_status_core #(.OP_CYC(OPC)) DUT (.clk(clk), .rst(rst), .sck(sck), .ce_n(ce_n),
    .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .status_o(status_o));
  fs_host_model host (.sck(sck), .ce_n(ce_n), .si(si), .so(so), .so_oe_n(so_oe_n));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic [7:0] exp);
    host.xfer(op, dat, (op == FS_OP_WRITE_STATUS_CMD) ? 2 : 1);
    @(negedge clk);
    chk(status_o, exp);
  endtask : cmd
  task automatic rdsr(input logic [7:0] exp);
    host.xfer(FS_OP_RDSR, 8'h00, 3);
    chk(host.rd_q[15:8], exp);
    chk(host.rd_q[7:0], exp);
  endtask : rdsr
  // wait out a write cycle, then busy and latch both low
  task automatic run_out(input logic [7:0] exp);
    int n;
    n = 0;
    while (status_o.busy === 1'b1 && n < OPC + 20)
    begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n < OPC}, 8'h01);
    chk(status_o, exp);
  endtask : run_out
  task automatic t_reset;
    chk(status_o, 8'h00);
    rdsr(8'h00);
  endtask : t_reset
  task automatic t_gate;
    for (int i = 0; i < 32; i++)
      cmd(FS_NV_OPS[i], 8'hfc, 8'h00);
    for (int i = 0; i < 6; i++)
      cmd(FS_VOL_OPS[i], 8'hfc, 8'h00);
    cmd(8'hc0, 8'hfc, 8'h00);
    cmd(8'h17, 8'hfc, 8'h00);
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(8'h63, 8'hfc, 8'h02);
    cmd(FS_OP_WRITE_DISABLE_CMD, 8'h00, 8'h00);
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(8'h62, 8'h00, 8'h03);
    run_out(8'h00);
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(8'h7e, 8'h00, 8'h03);
    run_out(8'h00);
  endtask : t_gate
  task automatic t_write_status_cmd;
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(FS_OP_WRITE_STATUS_CMD, 8'h54, 8'h57);
    rdsr(8'h57);
    cmd(FS_OP_WRITE_DISABLE_CMD, 8'h00, 8'h57);
    run_out(8'h54);
    rdsr(8'h54);
  endtask : t_write_status_cmd
  task automatic t_protect;
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h56);
    cmd(FS_OP_CER_A, 8'h00, 8'h56);
    cmd(FS_OP_WRITE_STATUS_CMD, 8'h80, 8'h83);
    run_out(8'h80);
    @(posedge clk);
    wp_n <= 1'b0;
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h82);
    cmd(FS_OP_WRITE_STATUS_CMD, 8'h7c, 8'h82);
    @(posedge clk);
    wp_n <= 1'b1;
    cmd(FS_OP_WRITE_STATUS_CMD, 8'h00, 8'h03);
    run_out(8'h00);
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(FS_OP_CER_B, 8'h00, 8'h03);
    run_out(8'h00);
  endtask : t_protect
  task automatic t_suspend;
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(8'h02, 8'h00, 8'h03);
    host.xfer(FS_OP_SUSP, 8'h00, 1);
    @(negedge clk);
    chk({7'h00, status_o.busy}, 8'h00);
    host.xfer(FS_OP_RESUME, 8'h00, 1);
    @(negedge clk);
    chk({7'h00, status_o.busy}, 8'h01);
    run_out(8'h00);
    cmd(FS_OP_WRITE_ENABLE_CMD, 8'h00, 8'h02);
    cmd(8'h20, 8'h00, 8'h03);
    cmd(FS_OP_RESET, 8'h00, 8'h00);
  endtask : t_suspend
  initial
  begin
    rst = 1'b1;
    wp_n = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset;
    t_gate;
    t_write_status_cmd;
    t_protect;
    t_suspend;
    conclude;
  end
  initial
  begin
    #1000000;
    err_count++;
    conclude;
  end
endmodule : tb_fs_status_core
